// ===== rtl/adcfg_defs.vh
// constants for the channel configuration and slot block
`ifndef ADCFG_DEFS_VH
`define ADCFG_DEFS_VH
// address/command byte fields
`define ADCFG_ACB_RSVD 7
`define ADCFG_ACB_XSEL 6
`define ADCFG_ACB_ADDR_HI 5
`define ADCFG_ACB_ADDR_LO 0
// channel control fields
`define ADCFG_CR_AS0 7
`define ADCFG_CR_AS1 6
`define ADCFG_CR_IPD 5
`define ADCFG_CR_ALGO_STATE_RESET 4
`define ADCFG_CR_BYP 3
`define ADCFG_CR_LAW 2
`define ADCFG_CR_AS2 1
`define ADCFG_CR_DIR 0
// reset values: idle set, all else clear
`define ADCFG_CR_RESET 8'h20
`define ADCFG_SLOT_RESET 6'h00
// algorithm codes as {as2,as1,as0}
`define ADCFG_ALG_32K 3'h0
`define ADCFG_ALG_24K 3'h7
`define ADCFG_ALG_16K 3'h5
// slot counts per frame
`define ADCFG_SLOTS_PCM_MU 7'd32
`define ADCFG_SLOTS_PCM_A 7'd32
`define ADCFG_SLOTS_ADPCM_MU 7'd64
`define ADCFG_SLOTS_ADPCM_A 7'd64
// bit widths of slots
`define ADCFG_WIDTH_PCM 4'd8
`define ADCFG_WIDTH_ADPCM 4'd4
// algorithm reset duration in system clocks
`define ADCFG_ALGO_STATE_RESET_NS 400
`define ADCFG_CLK_NS 40
`define ADCFG_ALGO_STATE_RESET_CYC ((`ADCFG_ALGO_STATE_RESET_NS + `ADCFG_CLK_NS - 1) / `ADCFG_CLK_NS)
`endif

// ===== rtl/adcfg_slot_ctr.v
// per-side slot counter: finds active input and output slots
`timescale 1ns/10ps
module adcfg_slot_ctr
(
	clk_sys,
	rst_n,
	bclk_rise,
	fsync,
	dir_comp,
	law_mu,
	in_slot,
	out_slot,
	in_active,
	out_active
);
`include "adcfg_defs.vh"
input wire clk_sys;
input wire rst_n;
input wire bclk_rise;
input wire fsync;
input wire dir_comp;
input wire law_mu;
input wire [5:0] in_slot;
input wire [5:0] out_slot;
output reg in_active;
output reg out_active;

reg armed_r;
reg run_r;
reg [8:0] bit_r;
wire [3:0] in_w;
wire [3:0] out_w;
wire [6:0] in_n;
wire [6:0] out_n;

// width picks bits per slot, count picks slots per frame
function [6:0] slot_count;
	input pcm;
	input mu;
	begin
		if (pcm)
			slot_count = mu ? `ADCFG_SLOTS_PCM_MU : `ADCFG_SLOTS_PCM_A;
		else
			slot_count = mu ? `ADCFG_SLOTS_ADPCM_MU : `ADCFG_SLOTS_ADPCM_A;
	end
endfunction

// compress: pcm in, adpcm out; expand: the reverse
// width and count
assign in_w = dir_comp ? `ADCFG_WIDTH_PCM : `ADCFG_WIDTH_ADPCM;
assign out_w = dir_comp ? `ADCFG_WIDTH_ADPCM : `ADCFG_WIDTH_PCM;
assign in_n = slot_count(dir_comp, law_mu);
assign out_n = slot_count(!dir_comp, law_mu);

// count bit clocks from first rising edge after frame sync
// start after sync
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		armed_r <= 1'b0;
		run_r <= 1'b0;
		bit_r <= 9'h000;
	end
	else if (fsync)
	begin
		armed_r <= 1'b1;
		run_r <= 1'b0;
		bit_r <= 9'h000;
	end
	else if (bclk_rise)
	begin
		if (armed_r)
		begin
			armed_r <= 1'b0;
			run_r <= 1'b1;
			bit_r <= 9'h000;
		end
		else if (run_r)
			bit_r <= bit_r + 9'h001;
	end
end

// compare current slot with programmed slot
// slot match
always @*
begin
	in_active = run_r &&
		(bit_r / {5'h00, in_w}) == {3'h0, in_slot} &&
		({3'h0, in_slot} < {2'h0, in_n});
	out_active = run_r &&
		(bit_r / {5'h00, out_w}) == {3'h0, out_slot} &&
		({3'h0, out_slot} < {2'h0, out_n});
end
endmodule

// ===== rtl/adcfg_top.v
// serial port, channel registers, pin-strap mode and slot timing
//
// Notes on behaviour
// - bypass only when bypass set, idle clear
// - bypass passes top nibble of each byte compressing, nibble then zeros expanding
// - control bit 2 picks a-law or mu-law
// - control bit 0 picks compress or expand
// - command bit 7 zero, bit 6 picks x
// - command bits 5..0 hold device address
// - bits 1,6,7 pick 32, 24, 16 kbit/s
// - control bit 5 idles channel, output off
// - control bit 4 resets algorithm state
// - input slot byte holds six-bit slot
// - output slot byte holds six-bit slot
// - counters from slot registers time data
// - slot width, count follow direction, law
// - slot layout ignores selected algorithm
// - counting starts first bit clock after sync
// - port-select low: pins drive idle, law, direction
// - pin-strapped mode fixes all slots at zero
// - address pins give direction and law
// - data pin idles y, select idles x
// - address pins 1, 4 give algorithm
// - select low, rising clock, lsb first
// - address mismatch ignores rest of write
// - algorithm reset bit self-clears when done
// - reset clears control except idle bits
`timescale 1ns/10ps
module adcfg_top
(
	clk_sys,
	arst_n,
	port_select_pin,
	sclk_pin,
	serial_in_pin,
	cs_n_pin,
	dev_addr_pin,
	side_x_frame_sync,
	side_x_bit_clock,
	side_x_data_in,
	side_y_frame_sync,
	side_y_bit_clock,
	side_y_data_in,
	side_x_data_out,
	side_x_data_oe_n,
	side_y_data_out,
	side_y_data_oe_n,
	x_channel_control,
	y_channel_control,
	x_algo_reset,
	y_algo_reset,
	x_in_slot_active,
	x_out_slot_active,
	y_in_slot_active,
	y_out_slot_active
);
`include "adcfg_defs.vh"
parameter ALGO_STATE_RESET_CYCLES = `ADCFG_ALGO_STATE_RESET_CYC;
input wire clk_sys;
input wire arst_n;
input wire port_select_pin;
input wire sclk_pin;
input wire serial_in_pin;
input wire cs_n_pin;
input wire [5:0] dev_addr_pin;
input wire side_x_frame_sync;
input wire side_x_bit_clock;
input wire side_x_data_in;
input wire side_y_frame_sync;
input wire side_y_bit_clock;
input wire side_y_data_in;
output reg side_x_data_out;
output reg side_x_data_oe_n;
output reg side_y_data_out;
output reg side_y_data_oe_n;
output reg [7:0] x_channel_control;
output reg [7:0] y_channel_control;
output reg x_algo_reset;
output reg y_algo_reset;
output reg x_in_slot_active;
output reg x_out_slot_active;
output reg y_in_slot_active;
output reg y_out_slot_active;

localparam ST_ACB = 2'b00;
localparam ST_CR = 2'b01;
localparam ST_ITR = 2'b10;
localparam ST_OTR = 2'b11;

////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

reg [1:0] rst_sync_r;
wire rst_n;
reg [1:0] s1_r;
reg [1:0] s2_r;
reg [1:0] cs1_r;
reg [1:0] di1_r;
reg [1:0] ps1_r;
reg [5:0] ad1_r;
reg [5:0] ad2_r;
reg [1:0] fs1_r;
reg [1:0] fs2_r;
reg [1:0] bc1_r;
reg [1:0] bc2_r;
reg [1:0] dn1_r;
reg [1:0] dn2_r;
reg sclk_d_r;
reg [1:0] bclk_d_r;
reg busy_r;

// two-stage release of the asynchronous reset
always @(posedge clk_sys or negedge arst_n)
begin
	if (!arst_n)
		rst_sync_r <= 2'b00;
	else
		rst_sync_r <= {rst_sync_r[0], 1'b1};
end
assign rst_n = rst_sync_r[1];

// every outside pin passes two flops
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		s1_r <= 2'b00;
		s2_r <= 2'b00;
		cs1_r <= 2'b11;
		di1_r <= 2'b00;
		// reset as serial mode so the idle reset value is not wiped
		ps1_r <= 2'b11;
		ad1_r <= 6'h00;
		ad2_r <= 6'h00;
		fs1_r <= 2'b00;
		fs2_r <= 2'b00;
		bc1_r <= 2'b00;
		bc2_r <= 2'b00;
		dn1_r <= 2'b00;
		dn2_r <= 2'b00;
		sclk_d_r <= 1'b0;
		bclk_d_r <= 2'b00;
	end
	else
	begin
		s1_r <= {s1_r[0], sclk_pin};
		s2_r <= s1_r;
		cs1_r <= {cs1_r[0], cs_n_pin};
		di1_r <= {di1_r[0], serial_in_pin};
		ps1_r <= {ps1_r[0], port_select_pin};
		ad1_r <= dev_addr_pin;
		ad2_r <= ad1_r;
		fs1_r <= {side_y_frame_sync, side_x_frame_sync};
		fs2_r <= fs1_r;
		bc1_r <= {side_y_bit_clock, side_x_bit_clock};
		bc2_r <= bc1_r;
		dn1_r <= {side_y_data_in, side_x_data_in};
		dn2_r <= dn1_r;
		sclk_d_r <= s1_r[1];
		bclk_d_r <= bc2_r;
	end
end

wire sclk_s = s1_r[1];
wire cs_n_s = cs1_r[1];
wire sdi_s = di1_r[1];
wire sw_mode = ps1_r[1];
wire sclk_rise = sclk_s && !sclk_d_r;
wire [1:0] bclk_rise = bc2_r & ~bclk_d_r;
wire [1:0] bclk_fall = ~bc2_r & bclk_d_r;

////////////////////////////////////////////////////////////////////////////
// serial write port

reg [1:0] st_r;
reg [2:0] bitn_r;
reg [7:0] shf_r;
reg match_r;
reg xsel_r;
reg [7:0] cr_x_r;
reg [7:0] cr_y_r;
reg [5:0] its_x_r;
reg [5:0] its_y_r;
reg [5:0] ots_x_r;
reg [5:0] ots_y_r;
reg [15:0] alc_x_r;
reg [15:0] alc_y_r;
wire [7:0] byte_nxt = {sdi_s, shf_r[7:1]};
wire byte_done = sclk_rise && !cs_n_s && bitn_r == 3'd7;

// shift lsb first on rising serial clock, select low
// serial sampling
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		st_r <= ST_ACB;
		bitn_r <= 3'd0;
		shf_r <= 8'h00;
		match_r <= 1'b0;
		xsel_r <= 1'b0;
		cr_x_r <= `ADCFG_CR_RESET;
		cr_y_r <= `ADCFG_CR_RESET;
		its_x_r <= `ADCFG_SLOT_RESET;
		its_y_r <= `ADCFG_SLOT_RESET;
		ots_x_r <= `ADCFG_SLOT_RESET;
		ots_y_r <= `ADCFG_SLOT_RESET;
		alc_x_r <= 16'h0000;
		alc_y_r <= 16'h0000;
		busy_r <= 1'b0;
	end
	else if (!sw_mode)
	begin
		st_r <= ST_ACB;
		bitn_r <= 3'd0;
		match_r <= 1'b0;
		busy_r <= 1'b0;
		cr_x_r <= 8'h00;
		cr_y_r <= 8'h00;
		its_x_r <= 6'h00;
		its_y_r <= 6'h00;
		ots_x_r <= 6'h00;
		ots_y_r <= 6'h00;
		alc_x_r <= 16'h0000;
		alc_y_r <= 16'h0000;
	end
	else
	begin
		busy_r <= !cs_n_s && match_r;
		if (cr_x_r[`ADCFG_CR_ALGO_STATE_RESET])
		begin
			alc_x_r <= alc_x_r + 16'h0001;
			if (alc_x_r == ALGO_STATE_RESET_CYCLES[15:0] - 16'h0001)
			begin
				cr_x_r[`ADCFG_CR_ALGO_STATE_RESET] <= 1'b0;
				alc_x_r <= 16'h0000;
			end
		end
		if (cr_y_r[`ADCFG_CR_ALGO_STATE_RESET])
		begin
			alc_y_r <= alc_y_r + 16'h0001;
			if (alc_y_r == ALGO_STATE_RESET_CYCLES[15:0] - 16'h0001)
			begin
				cr_y_r[`ADCFG_CR_ALGO_STATE_RESET] <= 1'b0;
				alc_y_r <= 16'h0000;
			end
		end
		if (cs_n_s)
		begin
			st_r <= ST_ACB;
			bitn_r <= 3'd0;
			match_r <= 1'b0;
		end
		else if (sclk_rise)
		begin
			shf_r <= byte_nxt;
			bitn_r <= bitn_r + 3'd1;
			if (byte_done)
			begin
				case (st_r)
				ST_ACB:
				begin
					match_r <= !byte_nxt[`ADCFG_ACB_RSVD] &&
						byte_nxt[`ADCFG_ACB_ADDR_HI:`ADCFG_ACB_ADDR_LO]
						== ad2_r;
					xsel_r <= byte_nxt[`ADCFG_ACB_XSEL];
					st_r <= ST_CR;
				end
				ST_CR:
				begin
					if (match_r && xsel_r)
						cr_x_r <= byte_nxt;
					if (match_r && !xsel_r)
						cr_y_r <= byte_nxt;
					st_r <= ST_ITR;
				end
				ST_ITR:
				begin
					if (match_r && xsel_r)
						its_x_r <= byte_nxt[5:0];
					if (match_r && !xsel_r)
						its_y_r <= byte_nxt[5:0];
					st_r <= ST_OTR;
				end
				ST_OTR:
				begin
					if (match_r && xsel_r)
						ots_x_r <= byte_nxt[5:0];
					if (match_r && !xsel_r)
						ots_y_r <= byte_nxt[5:0];
					match_r <= 1'b0;
					st_r <= ST_ACB;
				end
				default:
					st_r <= ST_ACB;
				endcase
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// effective configuration: registers or strap pins

reg [7:0] eff_x;
reg [7:0] eff_y;

// algorithm from pins 1 and 4
always @*
begin
	eff_x = cr_x_r;
	eff_y = cr_y_r;
	if (!sw_mode)
	begin
		eff_x = 8'h00;
		eff_y = 8'h00;
		eff_x[`ADCFG_CR_DIR] = ad2_r[0];
		eff_x[`ADCFG_CR_LAW] = ad2_r[2];
		eff_y[`ADCFG_CR_DIR] = ad2_r[3];
		eff_y[`ADCFG_CR_LAW] = ad2_r[5];
		eff_y[`ADCFG_CR_IPD] = sdi_s;
		eff_x[`ADCFG_CR_IPD] = cs_n_s;
		eff_x[`ADCFG_CR_AS0] = ad2_r[1] | ad2_r[4];
		eff_x[`ADCFG_CR_AS2] = ad2_r[1] | ad2_r[4];
		eff_x[`ADCFG_CR_AS1] = ad2_r[1] & ad2_r[4];
		eff_x[`ADCFG_CR_AS1] = eff_x[`ADCFG_CR_AS1] & ~ad2_r[1];
		eff_y[`ADCFG_CR_AS0] = eff_x[`ADCFG_CR_AS0];
		eff_y[`ADCFG_CR_AS1] = eff_x[`ADCFG_CR_AS1];
		eff_y[`ADCFG_CR_AS2] = eff_x[`ADCFG_CR_AS2];
	end
end

////////////////////////////////////////////////////////////////////////////
// slot timing per side

wire xi_act;
wire xo_act;
wire yi_act;
wire yo_act;

adcfg_slot_ctr u_x_slots
(
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.bclk_rise(bclk_rise[0]),
	.fsync(fs2_r[0]),
	.dir_comp(eff_x[`ADCFG_CR_DIR]),
	.law_mu(eff_x[`ADCFG_CR_LAW]),
	.in_slot(its_x_r),
	.out_slot(ots_x_r),
	.in_active(xi_act),
	.out_active(xo_act)
);

adcfg_slot_ctr u_y_slots
(
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.bclk_rise(bclk_rise[1]),
	.fsync(fs2_r[1]),
	.dir_comp(eff_y[`ADCFG_CR_DIR]),
	.law_mu(eff_y[`ADCFG_CR_LAW]),
	.in_slot(its_y_r),
	.out_slot(ots_y_r),
	.in_active(yi_act),
	.out_active(yo_act)
);

////////////////////////////////////////////////////////////////////////////
// bypass data path and output drive

reg [7:0] byp_x_r;
reg [7:0] byp_y_r;
wire byp_x = eff_x[`ADCFG_CR_BYP] && !eff_x[`ADCFG_CR_IPD];
wire byp_y = eff_y[`ADCFG_CR_BYP] && !eff_y[`ADCFG_CR_IPD];

// capture on falling bit clock, drive on rising edge
// bypass condition
always @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		byp_x_r <= 8'h00;
		byp_y_r <= 8'h00;
		side_x_data_out <= 1'b0;
		side_y_data_out <= 1'b0;
		side_x_data_oe_n <= 1'b1;
		side_y_data_oe_n <= 1'b1;
		x_channel_control <= `ADCFG_CR_RESET;
		y_channel_control <= `ADCFG_CR_RESET;
		x_algo_reset <= 1'b0;
		y_algo_reset <= 1'b0;
		x_in_slot_active <= 1'b0;
		x_out_slot_active <= 1'b0;
		y_in_slot_active <= 1'b0;
		y_out_slot_active <= 1'b0;
	end
	else
	begin
		if (bclk_fall[0] && xi_act)
			byp_x_r <= {byp_x_r[6:0], dn2_r[0]};
		else if (bclk_rise[0] && xo_act)
			byp_x_r <= {byp_x_r[6:0], 1'b0};
		if (bclk_fall[1] && yi_act)
			byp_y_r <= {byp_y_r[6:0], dn2_r[1]};
		else if (bclk_rise[1] && yo_act)
			byp_y_r <= {byp_y_r[6:0], 1'b0};
		// idle, no bypass or a write to this device address turns the output off at once
		if (bclk_rise[0])
		begin
			side_x_data_oe_n <= !(xo_act && byp_x && !busy_r);
			side_x_data_out <= eff_x[`ADCFG_CR_DIR] ?
				byp_x_r[7] : byp_x_r[3];
		end
		else if (!byp_x || busy_r)
			side_x_data_oe_n <= 1'b1;
		if (bclk_rise[1])
		begin
			side_y_data_oe_n <= !(yo_act && byp_y && !busy_r);
			side_y_data_out <= eff_y[`ADCFG_CR_DIR] ?
				byp_y_r[7] : byp_y_r[3];
		end
		else if (!byp_y || busy_r)
			side_y_data_oe_n <= 1'b1;
		x_channel_control <= eff_x;
		y_channel_control <= eff_y;
		x_algo_reset <= eff_x[`ADCFG_CR_ALGO_STATE_RESET];
		y_algo_reset <= eff_y[`ADCFG_CR_ALGO_STATE_RESET];
		x_in_slot_active <= xi_act;
		x_out_slot_active <= xo_act;
		y_in_slot_active <= yi_act;
		y_out_slot_active <= yo_act;
	end
end
endmodule

// ===== sim/adcfg_sva.sv
// assertion checker for the channel configuration and slot block
`timescale 1ns/10ps
module adcfg_sva
(
	input logic clk_sys,
	input logic arst_n,
	input logic port_select_pin,
	input logic serial_in_pin,
	input logic cs_n_pin,
	input logic [5:0] dev_addr_pin,
	input logic side_x_data_oe_n,
	input logic side_y_data_oe_n,
	input logic [7:0] x_channel_control,
	input logic [7:0] y_channel_control,
	input logic y_algo_reset,
	input logic x_in_slot_active
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!arst_n);
// strap mode with all mapped pins steady
sequence strap_steady;
	(!port_select_pin && $stable(dev_addr_pin) && $stable(cs_n_pin)
		&& $stable(serial_in_pin))[*8];
endsequence
AST_RST_CTRL: assert property (
	$rose(arst_n) |-> x_channel_control == 8'h20 && y_channel_control == 8'h20)
	else $error("control not idle after reset");
AST_X_IDLE_OFF: assert property (
	x_channel_control[5] && $past(x_channel_control[5]) |-> side_x_data_oe_n)
	else $error("idle x channel drives its output");
AST_Y_IDLE_OFF: assert property (
	y_channel_control[5] && $past(y_channel_control[5]) |-> side_y_data_oe_n)
	else $error("idle y channel drives its output");
AST_X_BYP_ONLY: assert property (
	!side_x_data_oe_n |-> x_channel_control[3] && !x_channel_control[5])
	else $error("x output driven outside bypass");
AST_STRAP_X: assert property (
	strap_steady |-> x_channel_control[0] == dev_addr_pin[0]
	&& x_channel_control[2] == dev_addr_pin[2]
	&& x_channel_control[5] == cs_n_pin && x_channel_control[4:3] == 2'h0)
	else $error("x control does not follow strap pins");
AST_STRAP_Y: assert property (
	strap_steady |-> y_channel_control[0] == dev_addr_pin[3]
	&& y_channel_control[2] == dev_addr_pin[5]
	&& y_channel_control[5] == serial_in_pin && y_channel_control[4:3] == 2'h0)
	else $error("y control does not follow strap pins");
AST_STRAP_ALG: assert property (
	strap_steady |-> {x_channel_control[1], x_channel_control[6],
	x_channel_control[7]} == ((dev_addr_pin[1] | dev_addr_pin[4]) ? 3'h5 : 3'h0))
	else $error("strap algorithm bits wrong");
AST_ALGO_STATE_RESET_DONE: assert property (
	$rose(y_algo_reset) |-> y_algo_reset[*2] ##[1:40] !y_algo_reset)
	else $error("algorithm reset did not end in time");
AST_SLOT_HOLD: assert property (
	$rose(x_in_slot_active) |-> x_in_slot_active[*8])
	else $error("input slot flag too short");
endmodule

// ===== sim/adcfg_host.sv
// host controller model on the three-wire configuration port
`timescale 1ns/10ps
module adcfg_host
(
	input logic clk_sys,
	output logic sclk_pin,
	output logic serial_in_pin,
	output logic cs_n_pin
);
// idle bus: clock low, select high
initial
begin
	sclk_pin = 1'b0;
	serial_in_pin = 1'b0;
	cs_n_pin = 1'b1;
end
// wait n clocks, then step off the edge
task tick(input integer n);
	repeat (n) @(posedge clk_sys);
	#1;
endtask
task write(input logic [31:0] w, input integer n);
	integer i;
	tick(1);
	cs_n_pin = 1'b0;
	for (i = 0; i < n * 8; i = i + 1)
	begin
		serial_in_pin = w[i];
		tick(4);
		sclk_pin = 1'b1;
		tick(4);
		sclk_pin = 1'b0;
	end
	tick(4);
	cs_n_pin = 1'b1;
	serial_in_pin = ~serial_in_pin;
	tick(2);
endtask
// clock held low in strap mode
task strap(input logic x_idle, input logic y_idle);
	sclk_pin = 1'b0;
	cs_n_pin = x_idle;
	serial_in_pin = y_idle;
endtask
endmodule

// ===== sim/adpcm_channel_config_and_slots_tb_top.sv
// testbench for the channel configuration and slot block
`timescale 1ns/10ps
module adpcm_channel_config_and_slots_tb_top;
logic clk_sys = 1'b0;
logic arst_n = 1'b0;
logic port_select_pin = 1'b1;
logic [5:0] dev_addr_pin = 6'h2A;
logic bclk = 1'b0;
logic fsync = 1'b0;
logic din = 1'b0;
logic [7:0] fcnt = 8'h00;
logic [7:0] bitn = 8'h00;
logic sclk_pin, serial_in_pin, cs_n_pin;
logic x_od, x_oe_n, y_od, y_oe_n, x_ra, y_ra, x_ia, x_oa, y_ia, y_oa;
logic [7:0] x_ctrl, y_ctrl;
logic [3:0] act;
integer fail_count = 0;
integer cmp_count = 0;
assign act = {y_oa, y_ia, x_oa, x_ia};
// system clock and an unrelated bit clock
always #20 clk_sys = ~clk_sys;
initial #7 forever #160 bclk = ~bclk;
// frame of 256 bits, sync one bit wide
always @(negedge bclk)
begin
	fcnt <= fcnt + 8'h01;
	fsync <= (fcnt == 8'hFF);
end
// bit index and changing line data
always @(posedge bclk)
begin
	bitn <= fcnt - 8'h01;
	din <= ~din ^ fcnt[2];
end
adcfg_host host (.clk_sys(clk_sys), .sclk_pin(sclk_pin),
	.serial_in_pin(serial_in_pin), .cs_n_pin(cs_n_pin));
adcfg_top #(.ALGO_STATE_RESET_CYCLES(20)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
	.port_select_pin(port_select_pin), .sclk_pin(sclk_pin),
	.serial_in_pin(serial_in_pin), .cs_n_pin(cs_n_pin),
	.dev_addr_pin(dev_addr_pin), .side_x_frame_sync(fsync),
	.side_x_bit_clock(bclk), .side_x_data_in(din),
	.side_y_frame_sync(fsync), .side_y_bit_clock(bclk),
	.side_y_data_in(din), .side_x_data_out(x_od),
	.side_x_data_oe_n(x_oe_n), .side_y_data_out(y_od),
	.side_y_data_oe_n(y_oe_n), .x_channel_control(x_ctrl),
	.y_channel_control(y_ctrl), .x_algo_reset(x_ra), .y_algo_reset(y_ra),
	.x_in_slot_active(x_ia), .x_out_slot_active(x_oa),
	.y_in_slot_active(y_ia), .y_out_slot_active(y_oa));
// compare and count
task chk(input logic [7:0] got, input logic [7:0] exp);
	cmp_count = cmp_count + 1;
	if (got !== exp)
	begin
		fail_count = fail_count + 1;
		$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
	end
endtask
// bit index where a slot flag rises in the next frame
task slot_at(input integer sel, input logic [7:0] exp);
	integer n;
	logic prev;
	@(posedge fsync);
	prev = act[sel];
	for (n = 0; n < 3000; n = n + 1)
	begin
		@(posedge clk_sys);
		if (!prev && act[sel])
			break;
		prev = act[sel];
	end
	if (n == 3000)
		fail_count = fail_count + 1;
	chk(bitn, exp);
endtask
// serial write, then compare both control bytes
task wr_chk(input logic [31:0] w, input integer n, input logic [7:0] ex,
	input logic [7:0] ey);
	host.write(w, n);
	repeat (4) @(posedge clk_sys);
	#1;
	chk(x_ctrl, ex);
	chk(y_ctrl, ey);
endtask
// verdict and end of run
task finish_test;
	$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
	if (fail_count == 0 && cmp_count > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
// watchdog well beyond the expected 0.6 ms
initial
begin
	#2000000;
	fail_count = fail_count + 1;
	finish_test;
end
// main sequence
initial
begin
	repeat (16) @(posedge clk_sys);
	#1 arst_n = 1'b1;
	repeat (8) @(posedge clk_sys);
	#1;
	chk(x_ctrl, 8'h20);
	chk(y_ctrl, 8'h20);
	$display("test reset done");
	// x bypass compress mu-law, slots 1 and 3
	wr_chk(32'h03010D6A, 4, 8'h0D, 8'h20);
	slot_at(0, 8'h08);
	slot_at(1, 8'h0C);
	// y expand a-law, slots 2 and 5
	wr_chk(32'h0502002A, 4, 8'h0D, 8'h00);
	slot_at(2, 8'h08);
	slot_at(3, 8'h28);
	$display("test slots done");
	// foreign address, then reserved bit set
	wr_chk(32'h5515, 2, 8'h0D, 8'h00);
	wr_chk(32'h55AA, 2, 8'h0D, 8'h00);
	// algorithm codes by two-byte writes
	wr_chk(32'hC22A, 2, 8'h0D, 8'hC2);
	slot_at(2, 8'h08);
	wr_chk(32'h002A, 2, 8'h0D, 8'h00);
	host.write(32'h962A, 2);
	chk({7'h00, y_ra}, 8'h01);
	repeat (30) @(posedge clk_sys);
	#1;
	chk({7'h00, y_ra}, 8'h00);
	chk(y_ctrl, 8'h86);
	$display("test control done");
	// strap mode: pins give direction, law, idle, algorithm
	host.strap(1'b0, 1'b1);
	dev_addr_pin = 6'h17;
	port_select_pin = 1'b0;
	repeat (8) @(posedge clk_sys);
	#1;
	chk(x_ctrl, 8'h87);
	chk(y_ctrl, 8'hA2);
	chk({7'h00, y_oe_n}, 8'h01);
	slot_at(0, 8'h00);
	slot_at(1, 8'h00);
	$display("test strap done");
	finish_test;
end
endmodule
bind adcfg_top adcfg_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n),
	.port_select_pin(port_select_pin), .serial_in_pin(serial_in_pin),
	.cs_n_pin(cs_n_pin), .dev_addr_pin(dev_addr_pin),
	.side_x_data_oe_n(side_x_data_oe_n), .side_y_data_oe_n(side_y_data_oe_n),
	.x_channel_control(x_channel_control),
	.y_channel_control(y_channel_control), .y_algo_reset(y_algo_reset),
	.x_in_slot_active(x_in_slot_active));
